//--- hdl/sgc_pkg.sv
// constants, types and helpers for the switch global configuration registers
// Operation
// - offset 0x0a factory-test byte resets to 0x35; software leaves it alone
// - bits 7 and 1 of 0x0b select LED mode, reset from strap pins
// - error-drop set: loopback drops OAM and CRC, undersize, oversize frames
// - error-drop clear: loopback drops only OAM frames, loops all others
// - loop position: 00 copper, 10 port 2 MAC, x1 port 1 optical
// - upper loop bit resets to one, lower bit from its strap
// - bit 0 of 0x0b enables direct-forward tag mode, reset disabled
// - tag n uses its 2-bit field; tags 0-3 at 0x0c, 4-7 at 0x0d
// - reset maps tags 0,1 to 00 and tags 2,3 to 01
// - reset maps tags 4,5 to 10 and tags 6,7 to 11
package sgc_pkg;

  // ----------------------------------------
  // register indices, byte address is index times four
  // ----------------------------------------
  localparam int SGC_ADR_W = 8;
  localparam logic [5:0] SGC_IDX_FACTORY = 6'h0a;
  localparam logic [5:0] SGC_IDX_CTRL = 6'h0b;
  localparam logic [5:0] SGC_IDX_PMAP_LO = 6'h0c;
  localparam logic [5:0] SGC_IDX_PMAP_HI = 6'h0d;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] SGC_FACTORY_RST = 8'h35;
  localparam logic [7:0] SGC_PMAP_LO_RST = 8'h50;
  localparam logic [7:0] SGC_PMAP_HI_RST = 8'hfa;
  localparam logic SGC_LOOP_HI_RST = 1'h1;
  localparam logic SGC_RSV6_RST = 1'h0;
  localparam logic SGC_TEST_RST = 1'h0;
  localparam logic SGC_TAG_MODE_RST = 1'h0;

  // ----------------------------------------
  // control register bit positions
  // ----------------------------------------
  localparam int SGC_B_LED_HI = 7;
  localparam int SGC_B_RSV6 = 6;
  localparam int SGC_B_ERR_DROP = 5;
  localparam int SGC_B_TEST = 4;
  localparam int SGC_B_LOOP_HI = 3;
  localparam int SGC_B_LOOP_LO = 2;
  localparam int SGC_B_LED_LO = 1;
  localparam int SGC_B_TAG_MODE = 0;

  // ----------------------------------------
  // strap synchroniser depth
  // ----------------------------------------
  localparam int SGC_SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    SGC_LOOP_COPPER = 3'h1,
    SGC_LOOP_MAC = 3'h2,
    SGC_LOOP_OPTICAL = 3'h4
  } sgc_loop_t;

  function automatic sgc_loop_t sgc_loop_decode(input logic hi, input logic lo);
    sgc_loop_t r;
    r = SGC_LOOP_COPPER;
    // low bit wins, high bit then ignored
    if (lo) begin
      r = SGC_LOOP_OPTICAL;
    end else if (hi) begin
      r = SGC_LOOP_MAC;
    end
    return r;
  endfunction

  function automatic logic [1:0] sgc_prio_lookup(input logic [15:0] map, input logic [2:0] tag);
    logic [1:0] r;
    r = map[{tag, 1'b0} +: 2];
    return r;
  endfunction

endpackage

//--- hdl/sgc_strap_sync.sv
// three-stage strap synchroniser with agreement filter
`timescale 1ns/1ns
module sgc_strap_sync #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);
  import sgc_pkg::*;

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // ----------------------------------------
  // filter
  // ----------------------------------------
  // not reset on purpose: straps must be sampled while srst is held
  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        level_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    s1_r <= pin;
    s2_r <= s1_r;
    s3_r <= s2_r;
    level_r <= level_nxt;
  end

  assign level = level_r;

endmodule

//--- hdl/sgc_loop_filter.sv
// per-frame loopback keep or drop verdict
`timescale 1ns/1ns
module sgc_loop_filter (
  input wire logic clk,
  input wire logic srst,
  input wire logic err_drop,
  input wire logic frame_done,
  input wire logic frame_oam,
  input wire logic frame_crc_err,
  input wire logic frame_undersize,
  input wire logic frame_oversize,
  output logic frame_loop,
  output logic frame_drop
);
  import sgc_pkg::*;

  logic loop_r;
  logic loop_nxt;
  logic drop_r;
  logic drop_nxt;
  logic bad;

  // ----------------------------------------
  // verdict
  // ----------------------------------------
  always_comb begin
    bad = frame_crc_err | frame_undersize | frame_oversize;
    loop_nxt = 1'b0;
    drop_nxt = 1'b0;
    if (frame_done) begin
      // errored frames dropped when error-drop set
      // only OAM dropped when error-drop clear
      drop_nxt = frame_oam | (err_drop & bad);
      loop_nxt = ~drop_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      loop_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      loop_r <= loop_nxt;
      drop_r <= drop_nxt;
    end
  end

  assign frame_loop = loop_r;
  assign frame_drop = drop_r;

endmodule

//--- hdl/sgc_regs.sv
// global configuration register bank with wishbone slave and config outputs
`timescale 1ns/1ns
module sgc_regs (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sgc_pkg::SGC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic led_style_hi_pin,
  input wire logic led_style_lo_pin,
  input wire logic loop_error_drop_strap,
  input wire logic loop_point_strap,
  input wire logic frame_done,
  input wire logic frame_oam,
  input wire logic frame_crc_err,
  input wire logic frame_undersize,
  input wire logic frame_oversize,
  output logic frame_loop,
  output logic frame_drop,
  input wire logic tag_valid,
  input wire logic [2:0] tag_value,
  output logic prio_valid,
  output logic [1:0] prio_value,
  output logic [1:0] led_style,
  output logic loop_error_drop,
  output sgc_pkg::sgc_loop_t loop_point,
  output logic test_mode,
  output logic direct_forward_tag_mode,
  output logic [7:0] factory_test
);
  import sgc_pkg::*;

  logic [3:0] strap_lvl;
  logic [7:0] factory_r;
  logic [7:0] factory_nxt;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] pmap_lo_r;
  logic [7:0] pmap_lo_nxt;
  logic [7:0] pmap_hi_r;
  logic [7:0] pmap_hi_nxt;
  logic [7:0] ctrl_rst;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic [5:0] idx;
  logic wr;
  logic take;
  sgc_loop_t loop_r;
  sgc_loop_t loop_nxt;
  logic prio_valid_r;
  logic prio_valid_nxt;
  logic [1:0] prio_r;
  logic [1:0] prio_nxt;

  // ----------------------------------------
  // decode helpers
  // ----------------------------------------
  function automatic logic reg_hit(input logic [5:0] at, input logic [5:0] code);
    logic r;
    r = (at == code);
    return r;
  endfunction

  // ----------------------------------------
  // strap inputs
  // ----------------------------------------
  // levels matter only while srst is held; later pin changes are ignored
  sgc_strap_sync #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .pin({led_style_hi_pin, led_style_lo_pin, loop_error_drop_strap, loop_point_strap}),
    .level(strap_lvl)
  );

  // ----------------------------------------
  // loopback frame verdict
  // ----------------------------------------
  // verdict for every frame; upstream decides whether loopback is active
  sgc_loop_filter u_filter (
    .clk(clk),
    .srst(srst),
    .err_drop(ctrl_r[SGC_B_ERR_DROP]),
    .frame_done(frame_done),
    .frame_oam(frame_oam),
    .frame_crc_err(frame_crc_err),
    .frame_undersize(frame_undersize),
    .frame_oversize(frame_oversize),
    .frame_loop(frame_loop),
    .frame_drop(frame_drop)
  );

  // ----------------------------------------
  // control reset image
  // ----------------------------------------
  // last edge in reset wins, so straps must be stable before release
  always_comb begin
    ctrl_rst = 8'h00;
    // led style taken from straps while reset held
    ctrl_rst[SGC_B_LED_HI] = strap_lvl[3];
    ctrl_rst[SGC_B_LED_LO] = strap_lvl[2];
    ctrl_rst[SGC_B_ERR_DROP] = strap_lvl[1];
    ctrl_rst[SGC_B_LOOP_HI] = SGC_LOOP_HI_RST;
    ctrl_rst[SGC_B_LOOP_LO] = strap_lvl[0];
    ctrl_rst[SGC_B_RSV6] = SGC_RSV6_RST;
    ctrl_rst[SGC_B_TEST] = SGC_TEST_RST;
    ctrl_rst[SGC_B_TAG_MODE] = SGC_TAG_MODE_RST;
  end

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // one wait state; ack drops the cycle after it is given
  always_comb begin
    take = wb_cyc_i & wb_stb_i & ~ack_r;
    idx = wb_adr_i[SGC_ADR_W-1:2];
    // lane 0 carries the byte; other lanes are acked and ignored
    wr = take & wb_we_i & wb_sel_i[0];
  end

  // ----------------------------------------
  // bus answer
  // ----------------------------------------
  // registered, so the answer always comes one cycle after the take
  always_comb begin
    ack_nxt = take;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= ack_nxt;
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // zero outside the answer cycle so stale data never shows on the bus
  always_comb begin
    dat_nxt = 32'h0000_0000;
    if (take & ~wb_we_i) begin
      unique case (idx)
        SGC_IDX_FACTORY: dat_nxt = {24'h00_0000, factory_r};
        SGC_IDX_CTRL: dat_nxt = {24'h00_0000, ctrl_r};
        SGC_IDX_PMAP_LO: dat_nxt = {24'h00_0000, pmap_lo_r};
        SGC_IDX_PMAP_HI: dat_nxt = {24'h00_0000, pmap_hi_r};
        default: dat_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      dat_r <= 32'h0000_0000;
    end else begin
      dat_r <= dat_nxt;
    end
  end

  // ----------------------------------------
  // factory-test byte
  // ----------------------------------------
  // plain storage; software is trusted to leave the reset value alone
  always_comb begin
    factory_nxt = factory_r;
    if (srst) begin
      factory_nxt = SGC_FACTORY_RST;
    end else if (wr && reg_hit(idx, SGC_IDX_FACTORY)) begin
      factory_nxt = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    factory_r <= factory_nxt;
  end

  // ----------------------------------------
  // led, loopback and tag-mode control
  // ----------------------------------------
  // reserved and test bits stored like the rest; software keeps them clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (srst) begin
      ctrl_nxt = ctrl_rst;
    end else if (wr && reg_hit(idx, SGC_IDX_CTRL)) begin
      // new mode reaches the loop logic next cycle
      ctrl_nxt = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    ctrl_r <= ctrl_nxt;
  end

  // ----------------------------------------
  // priority map, tags 0 to 3
  // ----------------------------------------
  // a write replaces all four fields at once
  always_comb begin
    pmap_lo_nxt = pmap_lo_r;
    if (srst) begin
      pmap_lo_nxt = SGC_PMAP_LO_RST;
    end else if (wr && reg_hit(idx, SGC_IDX_PMAP_LO)) begin
      pmap_lo_nxt = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    pmap_lo_r <= pmap_lo_nxt;
  end

  // ----------------------------------------
  // priority map, tags 4 to 7
  // ----------------------------------------
  always_comb begin
    pmap_hi_nxt = pmap_hi_r;
    if (srst) begin
      pmap_hi_nxt = SGC_PMAP_HI_RST;
    end else if (wr && reg_hit(idx, SGC_IDX_PMAP_HI)) begin
      pmap_hi_nxt = wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk) begin
    pmap_hi_r <= pmap_hi_nxt;
  end

  // ----------------------------------------
  // loop position
  // ----------------------------------------
  // decoded from the next value so the position moves with the register
  always_comb begin
    loop_nxt = sgc_loop_decode(ctrl_nxt[SGC_B_LOOP_HI], ctrl_nxt[SGC_B_LOOP_LO]);
  end

  always_ff @(posedge clk) begin
    loop_r <= loop_nxt;
  end

  // ----------------------------------------
  // priority lookup
  // ----------------------------------------
  // one answer per tag, back to back allowed; nothing queued behind it
  always_comb begin
    prio_valid_nxt = tag_valid;
    prio_nxt = 2'h0;
    if (tag_valid) begin
      prio_nxt = sgc_prio_lookup({pmap_hi_r, pmap_lo_r}, tag_value);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prio_valid_r <= 1'b0;
      prio_r <= 2'h0;
    end else begin
      prio_valid_r <= prio_valid_nxt;
      prio_r <= prio_nxt;
    end
  end

  // ----------------------------------------
  // bus outputs
  // ----------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------
  // forwarding outputs
  // ----------------------------------------
  assign prio_valid = prio_valid_r;
  assign prio_value = prio_r;
  assign loop_point = loop_r;

  // ----------------------------------------
  // configuration outputs
  // ----------------------------------------
  // all register bits, so no glitch reaches the led or loop logic
  assign led_style = {ctrl_r[SGC_B_LED_HI], ctrl_r[SGC_B_LED_LO]};
  assign loop_error_drop = ctrl_r[SGC_B_ERR_DROP];
  // software must keep this low; only reported here
  assign test_mode = ctrl_r[SGC_B_TEST];
  assign direct_forward_tag_mode = ctrl_r[SGC_B_TAG_MODE];
  assign factory_test = factory_r;

endmodule

//--- verif/sgc_regs_sva.sv
// checker for the global configuration register bank
`timescale 1ns/1ns
module sgc_regs_chk (
  input wire logic clk,
  input wire logic srst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sgc_pkg::SGC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic frame_done,
  input wire logic frame_oam,
  input wire logic frame_crc_err,
  input wire logic frame_undersize,
  input wire logic frame_oversize,
  input wire logic frame_loop,
  input wire logic frame_drop,
  input wire logic [1:0] led_style,
  input wire logic loop_error_drop,
  input wire logic [2:0] loop_point,
  input wire logic direct_forward_tag_mode,
  input wire logic [7:0] factory_test
);
  import sgc_pkg::*;
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  logic drop_exp_r;
  always_ff @(posedge clk) begin
    drop_exp_r <= frame_oam | (loop_error_drop & (frame_crc_err | frame_undersize | frame_oversize));
  end
  default clocking cb @(posedge clk); endclocking
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_wr(logic [5:0] idx);
    s_take ##0 (wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == idx);
  endsequence
  property p_ack;
    disable iff (srst) s_take |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer missing or too long");
  property p_ctrl;
    disable iff (srst) s_wr(SGC_IDX_CTRL) |=> led_style == {$past(wb_dat_i[7]), $past(wb_dat_i[1])}
      && loop_error_drop == $past(wb_dat_i[5]) && direct_forward_tag_mode == $past(wb_dat_i[0]);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control outputs not written");
  property p_loop;
    disable iff (srst) s_wr(SGC_IDX_CTRL) |=> loop_point == ($past(wb_dat_i[2]) ? SGC_LOOP_OPTICAL :
      $past(wb_dat_i[3]) ? SGC_LOOP_MAC : SGC_LOOP_COPPER);
  endproperty
  a_loop: assert property (p_loop) else $error("loop position decode wrong");
  property p_fact;
    disable iff (srst) s_wr(SGC_IDX_FACTORY) |=> factory_test == $past(wb_dat_i[7:0]);
  endproperty
  a_fact: assert property (p_fact) else $error("factory byte not written");
  property p_drop;
    disable iff (srst) frame_done |=> frame_drop == drop_exp_r && frame_loop == !drop_exp_r;
  endproperty
  a_drop: assert property (p_drop) else $error("frame verdict wrong");
  property p_idle;
    disable iff (srst) !frame_done |=> !frame_loop && !frame_drop;
  endproperty
  a_idle: assert property (p_idle) else $error("verdict without frame");
  property p_rst;
    $fell(srst) |-> factory_test == SGC_FACTORY_RST && !direct_forward_tag_mode && loop_point != SGC_LOOP_COPPER;
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_unmap;
    disable iff (srst) s_take ##0 (!wb_we_i && (wb_adr_i[7:2] < SGC_IDX_FACTORY || wb_adr_i[7:2] > SGC_IDX_PMAP_HI))
      |=> wb_dat_o == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
bind sgc_regs sgc_regs_chk u_chk (.clk, .srst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_dat_o, .wb_ack_o, .frame_done, .frame_oam, .frame_crc_err, .frame_undersize, .frame_oversize, .frame_loop,
  .frame_drop, .led_style, .loop_error_drop, .loop_point, .direct_forward_tag_mode, .factory_test);

//--- verif/tb.sv
// self-checking bench for the global configuration register bank
`timescale 1ns/1ns
module tb;
  import sgc_pkg::*;
  // ----------------------------------------
  // signals and design
  // ----------------------------------------
  logic clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fd = 1'b0, tv = 1'b0;
  logic [7:0] adr = 8'h00, ctrl, fact;
  logic [3:0] sel = 4'h0, fl = 4'h0, strap = 4'h0, v;
  logic [31:0] dat = 32'h0, dat_o;
  logic [2:0] tag = 3'h0;
  logic [15:0] map;
  logic ack, f_loop, f_drop, p_v, err_o, t_mode, dft, drop;
  logic [1:0] p_val, led;
  sgc_loop_t lp;
  logic [31:0] rd_q[$];
  logic [1:0] fr_q[$], pr_q[$];
  int fail_count = 0, comparisons = 0, seed = 41, i, k;
  always #25 clk = ~clk;
  sgc_regs DUT (.clk(clk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .led_style_hi_pin(strap[3]),
    .led_style_lo_pin(strap[0]), .loop_error_drop_strap(strap[2]), .loop_point_strap(strap[1]),
    .frame_done(fd), .frame_oam(fl[3]), .frame_crc_err(fl[2]), .frame_undersize(fl[1]),
    .frame_oversize(fl[0]), .frame_loop(f_loop), .frame_drop(f_drop), .tag_valid(tv), .tag_value(tag),
    .prio_valid(p_v), .prio_value(p_val), .led_style(led), .loop_error_drop(err_o), .loop_point(lp),
    .test_mode(t_mode), .direct_forward_tag_mode(dft), .factory_test(fact));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    if (fail_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // waits for ack under a bound; the answer is one cycle in normal use
  task wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, dat} <= {2'h3, w, a, s, 24'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!ack && k < 20);
    {cyc, stb} <= 2'h0;
    if (!ack) begin
      fail_count++;
      $display("[FAIL] ack expected 1 seen 0");
      conclude();
    end
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, a, 4'hf, 8'h00);
  endtask
  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (ack && !we) chk("rdata", rd_q.size() > 0 ? rd_q.pop_front() : 32'hx, dat_o);
    if (f_loop || f_drop) chk("verdict", fr_q.size() > 0 ? fr_q.pop_front() : 2'hx, {f_loop, f_drop});
    if (p_v) chk("prio", pr_q.size() > 0 ? pr_q.pop_front() : 2'hx, p_val);
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    strap <= 4'($random(seed));
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    ctrl = {strap[3], 1'b0, strap[2], 1'b0, 1'b1, strap[1], strap[0], 1'b0};
    chk("fact", 32'h35, fact);
    rd(8'h28, 32'h35);
    rd(8'h2c, {24'h0, ctrl});
    rd(8'h30, 32'h50);
    rd(8'h34, 32'hfa);
    rd(8'h38, 32'h0);
    wb(1'b1, 8'h28, 4'he, 8'h00);
    rd(8'h28, 32'h35);
    wb(1'b1, 8'h28, 4'h1, 8'h35);
    rd(8'h28, 32'h35);
    for (i = 0; i < 4; i++) begin
      ctrl = 8'($random(seed)) & 8'hc3 | {2'h0, i[0], 1'b0, i[1], i[0], 2'h0};
      wb(1'b1, 8'h2c, 4'h1, ctrl);
      chk("loop", ctrl[2] ? SGC_LOOP_OPTICAL : ctrl[3] ? SGC_LOOP_MAC : SGC_LOOP_COPPER, lp);
      chk("outs", {ctrl[7], ctrl[1], ctrl[5], ctrl[4], ctrl[0]}, {led, err_o, t_mode, dft});
      rd(8'h2c, {24'h0, ctrl});
      for (k = 0; k < 8; k++) begin
        v = 4'($random(seed));
        fd <= 1'b1;
        fl <= v;
        drop = v[3] | ctrl[5] & |v[2:0];
        fr_q.push_back({!drop, drop});
        @(posedge clk);
      end
      fd <= 1'b0;
    end
    map = 16'($random(seed));
    wb(1'b1, 8'h30, 4'h1, map[7:0]);
    wb(1'b1, 8'h34, 4'h1, map[15:8]);
    for (i = 0; i < 16; i++) begin
      tv <= 1'b1;
      tag <= i[2:0];
      pr_q.push_back(map[(i % 8) * 2 +: 2]);
      @(posedge clk);
    end
    tv <= 1'b0;
    repeat (4) @(posedge clk);
    // mid-run reset brings back the reset images
    srst <= 1'b1;
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    rd(8'h30, 32'h50);
    rd(8'h34, 32'hfa);
    rd(8'h28, 32'h35);
    repeat (4) @(posedge clk);
    chk("left", 32'h0, rd_q.size() + fr_q.size() + pr_q.size());
    conclude();
  end
endmodule
